//--- rtl/ddc_pkg.sv
// shared constants for the downconverter chain
package ddc_pkg;
	localparam int SMP_W    = 16;
	localparam int EXP_W    = 3;
	localparam int MIX_W    = 18;
	localparam int TRIG_W   = 16;
	localparam int PH_W     = 32;
	localparam int POFF_W   = 16;
	localparam int CIC_W    = 52;
	localparam int COEF_W   = 20;
	localparam int TAP_AW   = 8;
	localparam int TAPS_W   = 9;
	localparam int ACC_W    = 48;
	localparam int OUT_W    = 16;
	localparam int R1_W     = 5;
	localparam int R2_W     = 6;
	localparam int SHIFT_W  = 6;
	localparam int LFSR_W   = 16;
	localparam int DITH_W   = 4;
	localparam int OUT_LSB  = 21;
	localparam int SER_W    = 2 * OUT_W;
	localparam int SER_CW   = 6;
	localparam logic [1:0] MODE_COMPLEX = 2'h0;
	localparam logic [1:0] MODE_REAL    = 2'h1;
	localparam logic [1:0] MODE_DUAL    = 2'h2;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
	localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;
	localparam logic [R1_W-1:0] R1_ONE = 5'h01;
	localparam logic [R2_W-1:0] R2_ONE = 6'h01;
	localparam logic [TAPS_W-1:0] TAPS_ONE = 9'h001;
	typedef enum logic [1:0] {DDC_IDLE, DDC_RUN, DDC_DRAIN} ddc_mac_t;
endpackage

//--- rtl/ddc_mem_if.sv
// write/read port bundle between filter logic and its memories
`timescale 1ns/1ps
`default_nettype none
interface ddc_mem_if #(parameter int W = 20, parameter int AW = 8);
	logic          we;
	logic [AW-1:0] waddr;
	logic [W-1:0]  wdata;
	logic [AW-1:0] raddr;
	logic [W-1:0]  rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface
`default_nettype wire

//--- rtl/ddc_ram.sv
// simple dual-port memory, registered read data
`timescale 1ns/1ps
`default_nettype none
module ddc_ram #(
	parameter int W  = 20,
	parameter int AW = 8
) (
	input wire logic ref_clk_i,
	ddc_mem_if.mem   port
);
	logic [W-1:0] store [2**AW];
	logic [W-1:0] rdata_ff;

	always_ff @(posedge ref_clk_i) begin
		if (port.we)
			store[port.waddr] <= port.wdata;
		rdata_ff <= store[port.raddr];
	end
	assign port.rdata = rdata_ff;
endmodule
`default_nettype wire

//--- rtl/ddc_chain.sv
// receive downconverter: oscillator mixer, two comb decimators, tap filter
`timescale 1ns/1ps
`default_nettype none
module ddc_chain
	import ddc_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              srst_i,
	input  wire logic [SMP_W-1:0]  sample_i,
	input  wire logic [EXP_W-1:0]  exponent_input_i,
	input  wire logic              sample_strobe_i,
	input  wire logic [1:0]        input_mode_i,
	input  wire logic              channel_b_sel_i,
	input  wire logic              exponent_en_i,
	input  wire logic [PH_W-1:0]   tuning_word_i,
	input  wire logic [POFF_W-1:0] phase_offset_i,
	input  wire logic              phase_dither_en_i,
	input  wire logic              amp_dither_en_i,
	input  wire logic [R1_W-1:0]   first_decimation_ratio_i,
	input  wire logic [R2_W-1:0]   second_decimation_ratio_i,
	input  wire logic [SHIFT_W-1:0] comb_shift_i,
	input  wire logic              comb_bypass_i,
	input  wire logic [R2_W-1:0]   final_decimation_ratio_i,
	input  wire logic [TAPS_W-1:0] tap_count_i,
	input  wire logic              coef_we_i,
	input  wire logic [TAP_AW-1:0] coef_addr_i,
	input  wire logic [COEF_W-1:0] coef_data_i,
	input  wire logic              serial_sel_i,
	output logic [OUT_W-1:0]       out_i_o,
	output logic [OUT_W-1:0]       out_q_o,
	output logic                   out_valid_o,
	output logic                   serial_clk_o,
	output logic                   serial_data_o,
	output logic                   serial_frame_o,
	output logic                   filter_busy_o
);
	// three-stage capture of the converter pins
	logic [2:0] stb_sync_ff;
	logic       stb_lvl_ff;
	logic [SMP_W-1:0] smp_ff [3];
	logic [EXP_W-1:0] exp_ff [3];
	always_ff @(posedge ref_clk_i) begin
		stb_sync_ff <= {stb_sync_ff[1:0], sample_strobe_i};
		smp_ff <= '{sample_i, smp_ff[0], smp_ff[1]};
		exp_ff <= '{exponent_input_i, exp_ff[0], exp_ff[1]};
		if (srst_i)
			stb_lvl_ff <= 1'b0;
		else if (stb_sync_ff[1] == stb_sync_ff[2])
			stb_lvl_ff <= stb_sync_ff[2];
	end
	wire agree_hi = stb_sync_ff[1] & stb_sync_ff[2];
	wire word_evt = agree_hi & ~stb_lvl_ff;

	// gain-ranging: exponent attenuates the mantissa
	wire [EXP_W-1:0] exp_eff = exponent_en_i ? exp_ff[2] : '0;
	wire signed [MIX_W-1:0] word_val =
		$signed({smp_ff[2], 2'b00}) >>> exp_eff;

	// word pairing: second word of a pair is Q or channel B
	logic word_odd_ff;
	logic signed [MIX_W-1:0] held_ff;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			word_odd_ff <= 1'b0;
			held_ff <= '0;
		end else if (word_evt) begin
			word_odd_ff <= (input_mode_i == MODE_REAL) ? 1'b0 : ~word_odd_ff;
			held_ff <= word_val;
		end
	end
	wire is_real  = (input_mode_i != MODE_COMPLEX);
	wire take_cpx = (input_mode_i == MODE_COMPLEX) & word_odd_ff;
	wire take_dual = (input_mode_i == MODE_DUAL) &
		(word_odd_ff == channel_b_sel_i);
	wire take_real = (input_mode_i == MODE_REAL);
	wire mix_go = word_evt & (take_cpx | take_dual | take_real);
	wire signed [MIX_W-1:0] x_i = take_cpx ? held_ff : word_val;
	wire signed [MIX_W-1:0] x_q = is_real ? '0 : word_val;

	// oscillator
	logic [PH_W-1:0]   phase_ff;
	logic [LFSR_W-1:0] lfsr_ff;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			phase_ff <= '0;
			lfsr_ff <= LFSR_SEED;
		end else if (mix_go) begin
			phase_ff <= phase_ff + tuning_word_i;
			lfsr_ff <= lfsr_ff[0] ? (lfsr_ff >> 1) ^ LFSR_TAPS : lfsr_ff >> 1;
		end
	end
	wire [POFF_W-1:0] ph_dith = phase_dither_en_i ?
		{{(POFF_W-DITH_W){1'b0}}, lfsr_ff[DITH_W-1:0]} : '0;
	wire [POFF_W-1:0] ph_top = phase_ff[PH_W-1 -: POFF_W] +
		phase_offset_i + ph_dith;
	wire [TRIG_W-1:0] amp_dith = amp_dither_en_i ?
		{{(TRIG_W-1){1'b0}}, lfsr_ff[LFSR_W-1]} : '0;

	// parabolic sine, half-scale amplitude so dither cannot overflow
	function automatic logic signed [TRIG_W-1:0] sine(
		input logic [POFF_W-1:0] p);
		logic [POFF_W-2:0] x;
		logic [2*POFF_W-1:0] prod;
		logic [TRIG_W-1:0] mag;
		x = p[POFF_W-2:0];
		prod = {{(POFF_W+1){1'b0}}, x} *
			({{(POFF_W+1){1'b0}}, ~x} + 1'b1);
		mag = prod[POFF_W-2 +: TRIG_W];
		sine = p[POFF_W-1] ? -$signed(mag) : $signed(mag);
	endfunction
	localparam logic [POFF_W-1:0] QUARTER = 16'h4000;
	wire signed [TRIG_W-1:0] sin_v = sine(ph_top) + $signed(amp_dith);
	wire signed [TRIG_W-1:0] cos_v = sine(ph_top + QUARTER) +
		$signed(amp_dith);

	// multiply by e^-jwt
	wire signed [MIX_W+TRIG_W:0] mi = x_i * cos_v + x_q * sin_v;
	wire signed [MIX_W+TRIG_W:0] mq = x_q * cos_v - x_i * sin_v;
	logic signed [MIX_W-1:0] mix_ff [2];
	logic mix_vld_ff;
	always_ff @(posedge ref_clk_i) begin
		mix_vld_ff <= srst_i ? 1'b0 : mix_go;
		if (mix_go)
			mix_ff <= '{mi[TRIG_W +: MIX_W], mq[TRIG_W +: MIX_W]};
	end

	// decimation counters, ratios below one treated as one
	wire [R1_W-1:0] r1 = (first_decimation_ratio_i == '0) ? R1_ONE :
		first_decimation_ratio_i;
	wire [R2_W-1:0] r2 = (second_decimation_ratio_i == '0) ? R2_ONE :
		second_decimation_ratio_i;
	logic [R1_W-1:0] cnt1_ff;
	logic [R2_W-1:0] cnt2_ff;
	logic v1_ff, v2_ff;
	wire dec1 = mix_vld_ff & (cnt1_ff >= r1 - R1_ONE);
	wire dec2 = v1_ff & (cnt2_ff >= r2 - R2_ONE);
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cnt1_ff <= '0;
			cnt2_ff <= '0;
			v1_ff <= 1'b0;
			v2_ff <= 1'b0;
		end else begin
			v1_ff <= dec1;
			v2_ff <= dec2;
			if (mix_vld_ff)
				cnt1_ff <= dec1 ? '0 : cnt1_ff + R1_ONE;
			if (v1_ff)
				cnt2_ff <= dec2 ? '0 : cnt2_ff + R2_ONE;
		end
	end

	// per-channel comb chains; gains are not normalised, comb_shift_i does it
	logic signed [MIX_W-1:0] cic_out [2];
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic signed [CIC_W-1:0] a_ff [2];
		logic signed [CIC_W-1:0] d_ff [2];
		logic signed [CIC_W-1:0] o1_ff;
		logic signed [CIC_W-1:0] b_ff [5];
		logic signed [CIC_W-1:0] e_ff [5];
		logic signed [CIC_W-1:0] o2_ff;
		wire signed [CIC_W-1:0] c1a = a_ff[1] - d_ff[0];
		wire signed [CIC_W-1:0] c1b = c1a - d_ff[1];
		logic signed [CIC_W-1:0] cm [6];
		always_comb begin
			cm[0] = b_ff[4];
			for (int k = 0; k < 5; k++)
				cm[k+1] = cm[k] - e_ff[k];
		end
		always_ff @(posedge ref_clk_i) begin
			if (srst_i) begin
				a_ff <= '{default: '0};
				d_ff <= '{default: '0};
				b_ff <= '{default: '0};
				e_ff <= '{default: '0};
				o1_ff <= '0;
				o2_ff <= '0;
			end else begin
				if (mix_vld_ff) begin
					a_ff[0] <= a_ff[0] + CIC_W'(mix_ff[c]);
					a_ff[1] <= a_ff[1] + a_ff[0];
				end
				if (dec1) begin
					d_ff <= '{a_ff[1], c1a};
					o1_ff <= c1b;
				end
				if (v1_ff) begin
					b_ff[0] <= b_ff[0] + o1_ff;
					for (int k = 1; k < 5; k++)
						b_ff[k] <= b_ff[k] + b_ff[k-1];
				end
				if (dec2) begin
					for (int k = 0; k < 5; k++)
						e_ff[k] <= cm[k];
					o2_ff <= cm[5];
				end
			end
		end
		wire signed [CIC_W-1:0] scaled = o2_ff >>> comb_shift_i;
		assign cic_out[c] = scaled[MIX_W-1:0];
	end

	// both decimators bypassed together
	wire rcf_go = comb_bypass_i ? mix_vld_ff : v2_ff;
	wire [2*MIX_W-1:0] rcf_in = comb_bypass_i ?
		{mix_ff[0], mix_ff[1]} : {cic_out[0], cic_out[1]};

	// coefficient and history memories
	ddc_mem_if #(.W(COEF_W), .AW(TAP_AW)) coef_if ();
	ddc_mem_if #(.W(2*MIX_W), .AW(TAP_AW)) hist_if ();
	ddc_ram #(.W(COEF_W), .AW(TAP_AW)) u_coef (
		.ref_clk_i (ref_clk_i),
		.port      (coef_if.mem)
	);
	ddc_ram #(.W(2*MIX_W), .AW(TAP_AW)) u_hist (
		.ref_clk_i (ref_clk_i),
		.port      (hist_if.mem)
	);

	ddc_mac_t st_ff;
	logic [TAP_AW-1:0] wptr_ff, base_ff, k_ff;
	logic [TAPS_W-1:0] left_ff;
	logic [R2_W-1:0] cnt3_ff;
	logic acc_en_ff;
	logic signed [ACC_W-1:0] acc_ff [2];
	wire [R2_W-1:0] r3 = (final_decimation_ratio_i == '0) ? R2_ONE :
		final_decimation_ratio_i;
	wire [TAPS_W-1:0] taps = (tap_count_i == '0) ? TAPS_ONE : tap_count_i;
	wire dec3 = rcf_go & (cnt3_ff >= r3 - R2_ONE);
	wire start = dec3 & (st_ff == DDC_IDLE); // busy filter skips a start
	assign coef_if.we    = coef_we_i;
	assign coef_if.waddr = coef_addr_i;
	assign coef_if.wdata = coef_data_i;
	assign coef_if.raddr = k_ff;
	assign hist_if.we    = rcf_go;
	assign hist_if.waddr = wptr_ff;
	assign hist_if.wdata = rcf_in;
	assign hist_if.raddr = base_ff - k_ff;
	wire signed [COEF_W-1:0] cf = coef_if.rdata;
	wire signed [MIX_W-1:0] hi = hist_if.rdata[2*MIX_W-1 -: MIX_W];
	wire signed [MIX_W-1:0] hq = hist_if.rdata[MIX_W-1:0];
	wire signed [ACC_W-1:0] pi = ACC_W'(hi * cf);
	wire signed [ACC_W-1:0] pq = ACC_W'(hq * cf);
	wire fin = (st_ff == DDC_DRAIN);

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_ff <= DDC_IDLE;
			wptr_ff <= '0;
			base_ff <= '0;
			k_ff <= '0;
			left_ff <= '0;
			cnt3_ff <= '0;
			acc_en_ff <= 1'b0;
			acc_ff <= '{default: '0};
		end else begin
			if (rcf_go) begin
				wptr_ff <= wptr_ff + 1'b1;
				cnt3_ff <= dec3 ? '0 : cnt3_ff + R2_ONE;
			end
			acc_en_ff <= (st_ff == DDC_RUN);
			if (acc_en_ff)
				acc_ff <= '{acc_ff[0] + pi, acc_ff[1] + pq};
			case (st_ff)
				DDC_IDLE: if (start) begin
					st_ff <= DDC_RUN;
					base_ff <= wptr_ff;
					k_ff <= '0;
					left_ff <= taps;
					acc_ff <= '{default: '0};
				end
				DDC_RUN: begin
					k_ff <= k_ff + 1'b1;
					left_ff <= left_ff - TAPS_ONE;
					if (left_ff == TAPS_ONE)
						st_ff <= DDC_DRAIN;
				end
				DDC_DRAIN: if (!acc_en_ff)
					st_ff <= DDC_IDLE;
				default: st_ff <= DDC_IDLE;
			endcase
		end
	end
	wire done = fin & ~acc_en_ff;
	// parallel port keeps its last result while serial delivery is chosen
	wire par_done = done & ~serial_sel_i;
	assign filter_busy_o = (st_ff != DDC_IDLE);

	// parallel or serial delivery
	logic [SER_W-1:0] sh_ff;
	logic [SER_CW-1:0] bits_ff;
	logic sclk_ff, frame_ff;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			out_i_o <= '0;
			out_q_o <= '0;
			out_valid_o <= 1'b0;
			sh_ff <= '0;
			bits_ff <= '0;
			sclk_ff <= 1'b0;
			frame_ff <= 1'b0;
		end else begin
			out_valid_o <= par_done;
			if (par_done) begin
				out_i_o <= acc_ff[0][OUT_LSB +: OUT_W];
				out_q_o <= acc_ff[1][OUT_LSB +: OUT_W];
			end
			// serial clock runs at half rate, bit changes on its fall
			if (done & serial_sel_i & (bits_ff == '0)) begin
				sh_ff <= {acc_ff[0][OUT_LSB +: OUT_W],
					acc_ff[1][OUT_LSB +: OUT_W]};
				bits_ff <= SER_CW'(SER_W);
				sclk_ff <= 1'b0;
				frame_ff <= 1'b1;
			end else if (bits_ff != '0) begin
				sclk_ff <= ~sclk_ff;
				if (sclk_ff) begin
					sh_ff <= sh_ff << 1;
					bits_ff <= bits_ff - 1'b1;
					frame_ff <= 1'b0;
				end
			end
		end
	end
	assign serial_clk_o   = sclk_ff;
	assign serial_data_o  = sh_ff[SER_W-1];
	assign serial_frame_o = frame_ff;
endmodule
`default_nettype wire

//--- verification/ddc_chain_props.sv
// port checker for the downconverter chain
`timescale 1ns/1ps
`default_nettype none
module ddc_chain_props
	import ddc_pkg::*;
(
	input wire logic              ref_clk_i,
	input wire logic              srst_i,
	input wire logic [TAPS_W-1:0] tap_count_i,
	input wire logic [OUT_W-1:0]  out_i_o,
	input wire logic [OUT_W-1:0]  out_q_o,
	input wire logic              out_valid_o,
	input wire logic              serial_clk_o,
	input wire logic              serial_data_o,
	input wire logic              serial_frame_o,
	input wire logic              filter_busy_o
);
	logic       busy_ff;
	logic       sclk_ff;
	logic       frame_ff;
	logic [9:0] run_ff;
	logic [5:0] bits_ff;
	// zero taps behaves as one tap
	wire logic [9:0] taps_eff = (tap_count_i == '0) ? 10'h001
		: {1'b0, tap_count_i};
	always_ff @(posedge ref_clk_i) begin
		busy_ff <= filter_busy_o & ~srst_i;
		sclk_ff <= serial_clk_o & ~srst_i;
		frame_ff <= serial_frame_o & ~srst_i;
	end
	// cycles since the filter went busy, saturating
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || (filter_busy_o && !busy_ff))
			run_ff <= {9'h000, !srst_i};
		else if (run_ff != 10'h000 && run_ff != 10'h3ff)
			run_ff <= run_ff + 10'h001;
	end
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || (serial_frame_o && !frame_ff))
			bits_ff <= 6'h00;
		else if (serial_clk_o && !sclk_ff)
			bits_ff <= bits_ff + 6'h01;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	chk_valid_single:
	assert property (out_valid_o |=> !out_valid_o) else $error("valid long");
	chk_result_hold:
	assert property (!out_valid_o |-> $stable(out_i_o) && $stable(out_q_o))
		else $error("result moved");
	chk_tap_latency:
	assert property (out_valid_o |-> run_ff == taps_eff + 10'h002)
		else $error("tap latency");
	chk_reset_clear:
	assert property ($fell(srst_i) |-> out_i_o == '0 && out_q_o == '0
		&& !out_valid_o && !serial_frame_o && !serial_clk_o)
		else $error("reset state");
	chk_frame_shape:
	assert property ($rose(serial_frame_o) |-> !serial_clk_o
		##1 serial_frame_o && serial_clk_o ##1 !serial_frame_o)
		else $error("frame shape");
	chk_sclk_half:
	assert property (serial_clk_o |=> !serial_clk_o) else $error("sclk");
	chk_sdata_hold:
	assert property (serial_clk_o |-> $stable(serial_data_o))
		else $error("serial data moved");
	chk_bit_count:
	assert property ($rose(serial_frame_o) |-> bits_ff == 6'h20
		|| bits_ff == 6'h00) else $error("frame length");
	chk_sclk_idle:
	assert property (bits_ff == 6'h20 |-> !serial_clk_o)
		else $error("sclk after frame");
	cover property (out_valid_o);
	cover property ($rose(serial_frame_o));
	cover property (filter_busy_o && tap_count_i == 9'h100);
endmodule
bind ddc_chain ddc_chain_props u_props (.ref_clk_i, .srst_i, .tap_count_i,
	.out_i_o, .out_q_o, .out_valid_o, .serial_clk_o, .serial_data_o,
	.serial_frame_o, .filter_busy_o);
`default_nettype wire

//--- verification/ddc_adc_model.sv
// converter model driving sample words with a strobe
`timescale 1ns/1ps
`default_nettype none
module ddc_adc_model
	import ddc_pkg::*;
(
	input  wire logic             ref_clk_i,
	output var logic [SMP_W-1:0]  sample_o,
	output var logic [EXP_W-1:0]  exponent_o,
	output var logic              strobe_o
);
	initial begin
		sample_o = '0;
		exponent_o = '0;
		strobe_o = 1'b0;
	end
	// two high, two low: fastest device clock the chain allows
	task automatic send(input logic [SMP_W-1:0] w, input logic [EXP_W-1:0] e);
		@(posedge ref_clk_i);
		sample_o <= w;
		exponent_o <= e;
		strobe_o <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		strobe_o <= 1'b0;
		@(posedge ref_clk_i);
		// hold over, so the word is no longer guaranteed
		sample_o <= ~w;
		exponent_o <= ~e;
	endtask
endmodule
`default_nettype wire

//--- verification/ddc_chain_tb.sv
// self-checking bench for the downconverter chain
`timescale 1ns/1ps
`default_nettype none
module ddc_chain_tb
	import ddc_pkg::*;
;
	logic                ref_clk_i = 1'b0;
	logic                srst_i = 1'b1;
	logic [SMP_W-1:0]    sample_i;
	logic [EXP_W-1:0]    exponent_input_i;
	logic                sample_strobe_i;
	logic [1:0]          input_mode_i = MODE_REAL;
	logic                channel_b_sel_i = 1'b0;
	logic                exponent_en_i = 1'b0;
	logic [PH_W-1:0]     tuning_word_i = '0;
	logic [POFF_W-1:0]   phase_offset_i = '0;
	logic                phase_dither_en_i = 1'b0;
	logic                amp_dither_en_i = 1'b0;
	logic [R1_W-1:0]     first_decimation_ratio_i = R1_ONE;
	logic [R2_W-1:0]     second_decimation_ratio_i = R2_ONE;
	logic                comb_bypass_i = 1'b0;
	logic [R2_W-1:0]     final_decimation_ratio_i = R2_ONE;
	logic [TAPS_W-1:0]   tap_count_i = TAPS_ONE;
	logic                coef_we_i = 1'b0;
	logic [TAP_AW-1:0]   coef_addr_i = '0;
	logic [COEF_W-1:0]   coef_data_i = '0;
	logic                serial_sel_i = 1'b0;
	logic [OUT_W-1:0]    out_i_o;
	logic [OUT_W-1:0]    out_q_o;
	logic                out_valid_o;
	logic                serial_clk_o;
	logic                serial_data_o;
	logic                serial_frame_o;
	logic                filter_busy_o;
	int                  failures = 0;
	int                  checked = 0;
	int                  nvalid = 0;
	logic                sclk_d = 1'b0;
	logic [SER_W-1:0]    ser_word = '0;
	logic [POFF_W-1:0]   off_t [5] = '{16'h0000, 16'h4000, 16'h8000,
		16'h0000, 16'h0000};
	logic [1:0]          mode_t [5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2};
	// words enter the mixer left-justified, two bits above the pin word
	logic [SER_W-1:0]    res_t [5] = '{32'h08000000, 32'h0000f800,
		32'hf8000000, 32'h04000000, 32'h00000000};
	ddc_adc_model u_adc (.ref_clk_i, .sample_o(sample_i),
		.exponent_o(exponent_input_i), .strobe_o(sample_strobe_i));
	ddc_chain DUT (.ref_clk_i, .srst_i, .sample_i, .exponent_input_i,
		.sample_strobe_i, .input_mode_i, .channel_b_sel_i,
		.exponent_en_i, .tuning_word_i, .phase_offset_i, .phase_dither_en_i,
		.amp_dither_en_i, .first_decimation_ratio_i,
		.second_decimation_ratio_i, .comb_shift_i(6'h10), .comb_bypass_i,
		.final_decimation_ratio_i, .tap_count_i, .coef_we_i, .coef_addr_i,
		.coef_data_i, .serial_sel_i, .out_i_o, .out_q_o, .out_valid_o,
		.serial_clk_o, .serial_data_o, .serial_frame_o, .filter_busy_o);
	always #12.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		nvalid <= nvalid + int'(out_valid_o === 1'b1);
		sclk_d <= serial_clk_o;
		if (serial_clk_o === 1'b1 && sclk_d === 1'b0)
			ser_word <= {ser_word[SER_W-2:0], serial_data_o};
	end
	task automatic check(input string what, input logic [31:0] seen, want);
		checked++;
		if (seen !== want) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic conclude();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// a fresh reset per case, so decimation phases start from zero
	task automatic setup(input logic [1:0] m, input logic byp,
		input logic [R1_W-1:0] a, input logic [R2_W-1:0] b, c,
		input logic [TAPS_W-1:0] t, input logic [POFF_W-1:0] off,
		input logic [PH_W-1:0] tune, input logic ser);
		@(posedge ref_clk_i);
		srst_i <= 1'b1;
		input_mode_i <= m;
		comb_bypass_i <= byp;
		first_decimation_ratio_i <= a;
		second_decimation_ratio_i <= b;
		final_decimation_ratio_i <= c;
		tap_count_i <= t;
		phase_offset_i <= off;
		tuning_word_i <= tune;
		phase_dither_en_i <= tune[0];
		amp_dither_en_i <= tune[1];
		serial_sel_i <= ser;
		repeat (4) @(posedge ref_clk_i);
		srst_i <= 1'b0;
	endtask
	task automatic rate(input int words, input int outs);
		int base;
		base = nvalid;
		repeat (words) u_adc.send(16'h1234, 3'h0);
		repeat (400) @(posedge ref_clk_i);
		check("output count", nvalid - base, outs);
		check("busy at rest", filter_busy_o, 1'b0);
	endtask
	task automatic load_coefs(input logic [COEF_W-1:0] c0);
		for (int i = 0; i < 256; i++) begin
			@(posedge ref_clk_i);
			coef_we_i <= 1'b1;
			coef_addr_i <= i[TAP_AW-1:0];
			coef_data_i <= (i == 0) ? c0 : 20'h00001;
		end
		@(posedge ref_clk_i);
		coef_we_i <= 1'b0;
	endtask
	// a result shows as a valid pulse, or as a frame when serial is chosen
	task automatic wait_valid();
		int k;
		for (k = 0; k < 400; k++) begin
			if (out_valid_o === 1'b1 || serial_frame_o === 1'b1)
				break;
			@(posedge ref_clk_i);
		end
		if (k == 400) begin
			check("valid timeout", 32'h0, 32'h1);
			conclude();
		end
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		check("reset result", {out_i_o, out_q_o}, '0);
		check("reset flags", {out_valid_o, serial_clk_o, serial_frame_o}, '0);
		setup(MODE_REAL, 1'b0, 5'h02, 6'h01, 6'h01, 9'h001, '0, '0, 1'b0);
		rate(8, 4);
		setup(MODE_REAL, 1'b0, 5'h10, 6'h01, 6'h01, 9'h004, '0, '0, 1'b0);
		rate(32, 2);
		setup(MODE_REAL, 1'b0, 5'h01, 6'h01, 6'h01, 9'h001, '0, '0, 1'b0);
		rate(6, 6);
		setup(MODE_REAL, 1'b0, 5'h03, 6'h05, 6'h02, 9'h004, '0, 32'h1003, 1'b0);
		rate(60, 2);
		setup(MODE_REAL, 1'b0, 5'h02, 6'h20, 6'h01, 9'h008, '0, '0, 1'b0);
		rate(128, 2);
		setup(MODE_REAL, 1'b1, 5'h02, 6'h20, 6'h04, 9'h001, '0, '0, 1'b0);
		rate(8, 2);
		setup(MODE_COMPLEX, 1'b0, 5'h02, 6'h01, 6'h01, 9'h001, '0, '0, 1'b0);
		rate(8, 2);
		setup(MODE_DUAL, 1'b0, 5'h02, 6'h01, 6'h01, 9'h001, '0, '0, 1'b0);
		rate(8, 2);
		setup(MODE_REAL, 1'b0, 5'h10, 6'h08, 6'h20, 9'h100, '0, '0, 1'b0);
		rate(4096, 1);
		for (int r = 0; r < 5; r++) begin
			setup(mode_t[r], 1'b1, 5'h01, 6'h01, 6'h01, 9'h001, off_t[r], '0,
				r == 0);
			exponent_en_i <= (r == 3);
			channel_b_sel_i <= (r == 4);
			load_coefs(20'h40000);
			u_adc.send(16'h4000, 3'h1);
			if (mode_t[r] != MODE_REAL)
				u_adc.send(16'h0000, 3'h1);
			wait_valid();
			if (r == 0)
				check("parallel idle", {out_i_o, out_q_o}, '0);
			else
				check("result", {out_i_o, out_q_o}, res_t[r]);
			repeat (68) @(posedge ref_clk_i);
			if (r == 0)
				check("serial word", ser_word, res_t[0]);
		end
		conclude();
	end
endmodule
`default_nettype wire
